// ---- include/phy_rst_pkg.sv ----
// constants and types for the reset, power-down and interrupt block
package phy_rst_pkg;
  localparam logic [4:0] ADDR_BASIC_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STD_LAST = 5'h07;
  localparam logic [4:0] ADDR_SPEC_CTRL = 5'h11;
  localparam logic [4:0] ADDR_IRQ_1 = 5'h12;
  localparam logic [4:0] ADDR_IRQ_2 = 5'h13;
  localparam logic [4:0] ADDR_GLOBAL_RST = 5'h1F;

  localparam int BASIC_RESET_BIT = 15;
  localparam int BASIC_PWDN_BIT = 11;
  localparam int SPEC_INT_OE_BIT = 0;
  localparam int SPEC_INT_EN_BIT = 1;
  localparam int SPEC_INT_POL_BIT = 3;
  localparam int SPEC_PSAVE_EN_BIT = 14;
  localparam int SPEC_PSAVE_HI = 13;
  localparam int SPEC_PSAVE_LO = 12;
  localparam int GRST_RESET_BIT = 15;
  localparam int GRST_RESTART_BIT = 14;
  localparam int IRQ_STAT_LO = 8;

  localparam logic [15:0] BASIC_CTRL_RESET = 16'h0000;
  localparam logic [15:0] SPEC_CTRL_RESET = 16'h0000;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] IRQ_PEND_RESET = 8'h00;

  localparam logic [1:0] PSAVE_PWDN = 2'h1;
  localparam logic [1:0] PSAVE_WOL_ACTIVE = 2'h2;
  localparam logic [1:0] PSAVE_WOL_PASSIVE = 2'h3;

  localparam int STRAP_W = 8;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h00;

  localparam int CLK_MHZ = 250;
  localparam int SETTLE_US = 200;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int TMR_W = 17;

  typedef enum logic [1:0] {
    ST_HW_HOLD,
    ST_HW_SETTLE,
    ST_SW_SETTLE,
    ST_RUN
  } phase_t;
endpackage : phy_rst_pkg

// ---- rtl/phy_reset_powerdown_interrupt.sv ----
// reset sequencing, power-down control and interrupt pin of the transceiver
// What this block does
// - internal power-on reset starts the settle sequence; no external pulse needed
// - hardware reset restores register defaults and relatches bootstrap inputs
// - hardware reset completes internally about 200us after pin release
// - basic control bit 15 resets only standard registers 0x00 to 0x07
// - global reset bit 15 restores all registers, keeps latched straps
// - restart bit 14 restarts circuits, register contents untouched
// - software reset or restart completes about 200us after the write
// - shared pin is power-down input after reset; output when bit 0 set
// - specific control holds interrupt enable and output polarity
// - low shared pin in input mode powers the device down
// - all sources disabled after reset; per-source enables in 0x12, 0x13
// - enabled interrupt drives shared pin without waiting for a clock edge
// - status shows pending bits; any status read clears all of them
// - pin low or basic bit 11 powers down all but register access
// - specific bit 14 enables power-save, bits 13:12 select mode
// - codes 01 power-down, 10 active wake, 11 passive wake
// - clearing select bits powers up, returning to the prior state
`timescale 1ns/1ns
module phy_reset_powerdown_interrupt
  import phy_rst_pkg::*;
#(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hw_reset_n,
  input wire logic [STRAP_W-1:0] strap_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic [7:0] irq_event_1,
  input wire logic [7:0] irq_event_2,
  input wire logic shared_irq_powerdown_pin_in,
  output logic shared_irq_powerdown_pin_out,
  output logic shared_irq_powerdown_pin_oe,
  output logic core_run,
  output logic std_regs_reset,
  output logic [STRAP_W-1:0] strap_latched,
  output logic powerdown,
  output logic wake_on_network_active,
  output logic wake_on_network_passive
);
  typedef struct packed {
    phase_t phase;
    logic [15:0] basic_mode_control;
    logic [15:0] phy_specific_control;
    logic [7:0] irq_en_1;
    logic [7:0] irq_en_2;
    logic [7:0] irq_pend_1;
    logic [7:0] irq_pend_2;
    logic glob_rst;
    logic restart;
    logic [STRAP_W-1:0] strap;
    logic [15:0] rdata;
    logic rd_valid;
    logic std_rst;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic [7:0] set_1;
  logic [7:0] set_2;
  logic rd_ok;
  logic wr_ok;
  logic stat_clear;
  logic irq_active;
  logic int_oe;
  logic int_en;
  logic int_pol;
  logic psave_en;
  logic [1:0] psave_sel;

  // register file back to defaults; latched straps survive
  function automatic state_t regs_default(input state_t s);
    state_t r;
    r = s;
    r.basic_mode_control = BASIC_CTRL_RESET;
    r.phy_specific_control = SPEC_CTRL_RESET;
    r.irq_en_1 = IRQ_EN_RESET;
    r.irq_en_2 = IRQ_EN_RESET;
    r.irq_pend_1 = IRQ_PEND_RESET;
    r.irq_pend_2 = IRQ_PEND_RESET;
    return r;
  endfunction : regs_default

  function automatic logic is_status(input logic [4:0] a);
    return (a == ADDR_IRQ_1) || (a == ADDR_IRQ_2);
  endfunction : is_status

  settle_timer #(
    .CYCLES(SETTLE_CYCLES_P)
  ) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .start(tmr_start),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  assign int_oe = s_reg.phy_specific_control[SPEC_INT_OE_BIT];
  assign int_en = s_reg.phy_specific_control[SPEC_INT_EN_BIT];
  assign int_pol = s_reg.phy_specific_control[SPEC_INT_POL_BIT];
  assign psave_en = s_reg.phy_specific_control[SPEC_PSAVE_EN_BIT];
  assign psave_sel = s_reg.phy_specific_control[SPEC_PSAVE_HI:SPEC_PSAVE_LO];

  assign set_1 = irq_event_1 & s_reg.irq_en_1;
  assign set_2 = irq_event_2 & s_reg.irq_en_2;
  assign rd_ok = reg_rd && (s_reg.phase != ST_HW_HOLD);
  assign wr_ok = reg_wr && (s_reg.phase != ST_HW_HOLD);
  assign stat_clear = rd_ok && is_status(reg_addr);

  always_comb begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    s_next.std_rst = 1'b0;
    tmr_start = 1'b0;
    // new events win over the read clear in the same cycle
    s_next.irq_pend_1 = (stat_clear ? IRQ_PEND_RESET : s_reg.irq_pend_1) | set_1;
    s_next.irq_pend_2 = (stat_clear ? IRQ_PEND_RESET : s_reg.irq_pend_2) | set_2;
    if (rd_ok) begin
      s_next.rd_valid = 1'b1;
      case (reg_addr)
        ADDR_BASIC_CTRL: s_next.rdata = s_reg.basic_mode_control;
        ADDR_SPEC_CTRL: s_next.rdata = s_reg.phy_specific_control;
        ADDR_IRQ_1: s_next.rdata = {s_reg.irq_pend_1, s_reg.irq_en_1};
        ADDR_IRQ_2: s_next.rdata = {s_reg.irq_pend_2, s_reg.irq_en_2};
        ADDR_GLOBAL_RST: s_next.rdata = {s_reg.glob_rst, s_reg.restart, 14'h0000};
        default: s_next.rdata = 16'h0000;
      endcase
    end
    if (wr_ok) begin
      case (reg_addr)
        ADDR_BASIC_CTRL: begin
          if (reg_wdata[BASIC_RESET_BIT]) begin
            s_next.basic_mode_control = BASIC_CTRL_RESET;
            s_next.std_rst = 1'b1;
          end else begin
            s_next.basic_mode_control = reg_wdata;
          end
        end
        ADDR_SPEC_CTRL: s_next.phy_specific_control = reg_wdata;
        ADDR_IRQ_1: s_next.irq_en_1 = reg_wdata[7:0];
        ADDR_IRQ_2: s_next.irq_en_2 = reg_wdata[7:0];
        ADDR_GLOBAL_RST: begin
          if (reg_wdata[GRST_RESET_BIT]) begin
            s_next = regs_default(s_next);
            s_next.glob_rst = 1'b1;
            s_next.phase = ST_SW_SETTLE;
            tmr_start = 1'b1;
          end else if (reg_wdata[GRST_RESTART_BIT]) begin
            s_next.restart = 1'b1;
            s_next.phase = ST_SW_SETTLE;
            tmr_start = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    case (s_reg.phase)
      ST_HW_HOLD: begin
        if (hw_reset_n) begin
          s_next.phase = ST_HW_SETTLE;
          tmr_start = 1'b1;
        end
      end
      ST_HW_SETTLE: begin
        // a reset write in the done cycle keeps its own settle phase
        if (tmr_done && !tmr_start) begin
          s_next.strap = strap_in;
          s_next.phase = ST_RUN;
        end
      end
      ST_SW_SETTLE: begin
        if (tmr_done && !tmr_start) begin
          s_next.glob_rst = 1'b0;
          s_next.restart = 1'b0;
          s_next.phase = ST_RUN;
        end
      end
      ST_RUN: begin
      end
      default: s_next.phase = ST_HW_HOLD;
    endcase
    if (!hw_reset_n) begin
      s_next = regs_default(s_next);
      s_next.glob_rst = 1'b0;
      s_next.restart = 1'b0;
      s_next.rd_valid = 1'b0;
      s_next.std_rst = 1'b0;
      s_next.phase = ST_HW_HOLD;
      tmr_start = 1'b0;
    end
  end

  // power-on reset lands in the settle phase with the timer already loaded
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{
        phase: ST_HW_SETTLE,
        basic_mode_control: BASIC_CTRL_RESET,
        phy_specific_control: SPEC_CTRL_RESET,
        irq_en_1: IRQ_EN_RESET,
        irq_en_2: IRQ_EN_RESET,
        irq_pend_1: IRQ_PEND_RESET,
        irq_pend_2: IRQ_PEND_RESET,
        glob_rst: 1'b0,
        restart: 1'b0,
        strap: STRAP_RESET,
        rdata: 16'h0000,
        rd_valid: 1'b0,
        std_rst: 1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // fresh events reach the pin in the same cycle, not at the next edge
  assign irq_active = int_oe && int_en &&
    (((s_reg.irq_pend_1 | s_reg.irq_pend_2) != 8'h00) || ((set_1 | set_2) != 8'h00));
  assign shared_irq_powerdown_pin_oe = int_oe;
  assign shared_irq_powerdown_pin_out = int_pol ? irq_active : !irq_active;

  assign powerdown = (!int_oe && !shared_irq_powerdown_pin_in) ||
    s_reg.basic_mode_control[BASIC_PWDN_BIT] ||
    (psave_en && (psave_sel == PSAVE_PWDN));
  assign wake_on_network_active = psave_en && (psave_sel == PSAVE_WOL_ACTIVE);
  assign wake_on_network_passive = psave_en && (psave_sel == PSAVE_WOL_PASSIVE);

  assign core_run = (s_reg.phase == ST_RUN);
  assign std_regs_reset = s_reg.std_rst;
  assign strap_latched = s_reg.strap;
  assign reg_rdata = s_reg.rdata;
  assign reg_rdata_valid = s_reg.rd_valid;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  property p_irq_fast;
    int_oe && int_en && ((set_1 | set_2) != 8'h00) |->
      shared_irq_powerdown_pin_out == int_pol;
  endproperty
  a_irq_fast: assert property (p_irq_fast) else $error("interrupt pin late");

  property p_read_clear;
    stat_clear && hw_reset_n && (set_1 == 8'h00) && (set_2 == 8'h00)
      |=> (s_reg.irq_pend_1 == 8'h00) && (s_reg.irq_pend_2 == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

  property p_set_wins;
    stat_clear && (set_1 != 8'h00) && hw_reset_n |=> (s_reg.irq_pend_1 & $past(set_1)) != 8'h00;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost at clear");

  property p_pin_input;
    !int_oe |-> !shared_irq_powerdown_pin_oe && (powerdown || shared_irq_powerdown_pin_in);
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("pin not a power-down input");

  property p_bit11_pd;
    s_reg.basic_mode_control[BASIC_PWDN_BIT] |-> powerdown;
  endproperty
  a_bit11_pd: assert property (p_bit11_pd) else $error("power-down bit ignored");

  property p_global_rst;
    wr_ok && hw_reset_n && reg_addr == ADDR_GLOBAL_RST && reg_wdata[GRST_RESET_BIT] |=>
      s_reg.phy_specific_control == SPEC_CTRL_RESET && !core_run && $stable(s_reg.strap);
  endproperty
  a_global_rst: assert property (p_global_rst) else $error("global reset wrong");

  property p_restart;
    wr_ok && hw_reset_n && reg_addr == ADDR_GLOBAL_RST && !reg_wdata[GRST_RESET_BIT] &&
      reg_wdata[GRST_RESTART_BIT] |=> !core_run && $stable(s_reg.phy_specific_control);
  endproperty
  a_restart: assert property (p_restart) else $error("restart touched registers");

  property p_run_after_timer;
    $rose(core_run) |-> $past(tmr_done) && !tmr_busy;
  endproperty
  a_run_after_timer: assert property (p_run_after_timer) else $error("settle cut short");

  property p_std_rst;
    wr_ok && hw_reset_n && reg_addr == ADDR_BASIC_CTRL && reg_wdata[BASIC_RESET_BIT] |=>
      std_regs_reset && s_reg.basic_mode_control == BASIC_CTRL_RESET &&
      $stable(s_reg.phy_specific_control);
  endproperty
  a_std_rst: assert property (p_std_rst) else $error("standard reset wrong");

  property p_hw_hold;
    !hw_reset_n |=> s_reg.phase == ST_HW_HOLD && s_reg.irq_en_1 == IRQ_EN_RESET &&
      s_reg.phy_specific_control == SPEC_CTRL_RESET;
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("hardware reset incomplete");

  property p_wake;
    psave_en && psave_sel == PSAVE_WOL_ACTIVE |-> wake_on_network_active &&
      !wake_on_network_passive;
  endproperty
  a_wake: assert property (p_wake) else $error("wake mode decode wrong");

  property p_resume;
    !psave_en && int_oe && !s_reg.basic_mode_control[BASIC_PWDN_BIT] |-> !powerdown;
  endproperty
  a_resume: assert property (p_resume) else $error("power-down stuck");

  property p_irq_hold;
    int_oe && int_en && (s_reg.irq_pend_2 != 8'h00) |->
      shared_irq_powerdown_pin_out == int_pol;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");
endmodule : phy_reset_powerdown_interrupt

// ---- rtl/settle_timer.sv ----
// down counter timing the internal settle after power-on, pin or global reset or restart
`timescale 1ns/1ns
module settle_timer
  import phy_rst_pkg::*;
#(
  parameter int CYCLES = SETTLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic done;
  } tmr_t;

  localparam logic [TMR_W-1:0] LOAD = TMR_W'(CYCLES);

  tmr_t s_reg;
  tmr_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start) begin
      s_next.cnt = LOAD;
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - TMR_W'(1);
      s_next.done = (s_reg.cnt == TMR_W'(1));
    end
  end

  // counting from power-on reset provides the internal power-up settle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{cnt: LOAD, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = (s_reg.cnt != '0);
  assign done = s_reg.done;
endmodule : settle_timer

// ---- tb/phy_reset_powerdown_interrupt_test.sv ----
// self-checking bench for the reset, power-down and interrupt block
`timescale 1ns/1ns
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module phy_reset_powerdown_interrupt_test
  import phy_rst_pkg::*;
;
  localparam int SETTLE = 20;
  typedef struct packed {logic w; logic [4:0] a; logic [15:0] d; logic [15:0] q; logic [2:0] m;} row_t;
  row_t rows [16] = '{
    '{1'b0, 5'h00, 16'h0000, 16'h0000, 3'h0}, '{1'b0, 5'h11, 16'h0000, 16'h0000, 3'h0},
    '{1'b0, 5'h12, 16'h0000, 16'h0000, 3'h0}, '{1'b0, 5'h13, 16'h0000, 16'h0000, 3'h0},
    '{1'b0, 5'h1F, 16'h0000, 16'h0000, 3'h0}, '{1'b1, 5'h00, 16'h0800, 16'h0800, 3'h4},
    '{1'b1, 5'h00, 16'h0000, 16'h0000, 3'h0}, '{1'b1, 5'h11, 16'h5000, 16'h5000, 3'h4},
    '{1'b1, 5'h11, 16'h6000, 16'h6000, 3'h2}, '{1'b1, 5'h11, 16'h7000, 16'h7000, 3'h1},
    '{1'b1, 5'h11, 16'h4000, 16'h4000, 3'h0}, '{1'b1, 5'h11, 16'h3000, 16'h3000, 3'h0},
    '{1'b1, 5'h0A, 16'h1234, 16'h0000, 3'h0}, '{1'b1, 5'h12, 16'h00FF, 16'h00FF, 3'h0},
    '{1'b1, 5'h13, 16'hFF0F, 16'h000F, 3'h0}, '{1'b1, 5'h11, 16'h0000, 16'h0000, 3'h0}};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [STRAP_W-1:0] strap_in = 8'hA5;
  logic [7:0] irq_event_1 = 8'h00;
  logic [7:0] irq_event_2 = 8'h00;
  logic ext_low = 1'b0;
  logic pin_in, reg_wr, reg_rd, hw_reset_n, reg_rdata_valid, pin_out, pin_oe;
  logic core_run, std_regs_reset, powerdown, wake_act, wake_pas;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [STRAP_W-1:0] strap_latched;
  int err_total = 0;
  int total_checks = 0;
  int n;
  int std_pulses = 0;

  always #2 mclk = ~mclk;
  // weak pull-up unless the device or an external driver pulls low
  assign pin_in = pin_oe ? pin_out : ~ext_low;
  always @(posedge mclk) if (std_regs_reset === 1'b1) std_pulses++;

  phy_reset_powerdown_interrupt #(.SETTLE_CYCLES_P(SETTLE)) uut (.mclk(mclk), .rstn(rstn),
    .hw_reset_n(hw_reset_n), .strap_in(strap_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .irq_event_1(irq_event_1), .irq_event_2(irq_event_2),
    .shared_irq_powerdown_pin_in(pin_in), .shared_irq_powerdown_pin_out(pin_out),
    .shared_irq_powerdown_pin_oe(pin_oe), .core_run(core_run), .std_regs_reset(std_regs_reset),
    .strap_latched(strap_latched), .powerdown(powerdown), .wake_on_network_active(wake_act),
    .wake_on_network_passive(wake_pas));

  station_manager #(.WAIT_CYCLES(SETTLE * 5 / 2)) u_mgr (.mclk(mclk), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .hw_reset_n(hw_reset_n));

  task automatic end_of_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic wait_run(output int c);
    c = 0;
    while (core_run !== 1'b1 && c < 200) begin
      @(negedge mclk);
      c++;
    end
    `CHECK(c inside {[SETTLE - 3 : SETTLE + 3]}, 1'b1)
  endtask : wait_run

  task automatic pulse_irq(input logic [7:0] e1, input logic exp_pin);
    @(negedge mclk);
    irq_event_1 = e1;
    #1 `CHECK(pin_out, exp_pin)
    @(negedge mclk);
    irq_event_1 = 8'h00;
  endtask : pulse_irq

  initial begin
    #(20000 * 4);
    err_total++;
    end_of_test();
  end

  initial begin
    #(6 * 4) rstn = 1'b1;
    `CHECK({core_run, pin_oe, pin_out}, 3'b001)
    wait_run(n);
    `CHECK(strap_latched, 8'hA5)
    foreach (rows[i]) begin
      if (rows[i].w) u_mgr.wr(rows[i].a, rows[i].d);
      u_mgr.rd(rows[i].a, rd_val);
      `CHECK(rd_val, rows[i].q)
      `CHECK({powerdown, wake_act, wake_pas}, rows[i].m)
    end
    @(negedge mclk);
    ext_low = 1'b1;
    #1 `CHECK(powerdown, 1'b1)
    @(negedge mclk);
    ext_low = 1'b0;
    #1 `CHECK(powerdown, 1'b0)
    u_mgr.wr(ADDR_SPEC_CTRL, 16'h0003);
    u_mgr.wr(ADDR_IRQ_1, 16'h0001);
    u_mgr.wr(ADDR_IRQ_2, 16'h0000);
    `CHECK({pin_oe, pin_out}, 2'b11)
    pulse_irq(8'h01, 1'b0);
    irq_event_2 = 8'h80;
    @(negedge mclk);
    irq_event_2 = 8'h00;
    `CHECK(pin_out, 1'b0)
    u_mgr.rd(ADDR_IRQ_1, rd_val);
    `CHECK(rd_val, 16'h0101)
    @(negedge mclk);
    `CHECK(pin_out, 1'b1)
    u_mgr.rd(ADDR_IRQ_2, rd_val);
    `CHECK(rd_val, 16'h0000)
    pulse_irq(8'h01, 1'b0);
    u_mgr.rd(ADDR_IRQ_2, rd_val);
    u_mgr.rd(ADDR_IRQ_1, rd_val);
    `CHECK(rd_val, 16'h0001)
    // event in the very cycle of a status read must survive the clear
    fork
      u_mgr.rd(ADDR_IRQ_1, rd_val);
      begin
        @(negedge mclk);
        irq_event_1 = 8'h01;
        @(negedge mclk);
        irq_event_1 = 8'h00;
      end
    join
    `CHECK(rd_val, 16'h0001)
    u_mgr.rd(ADDR_IRQ_1, rd_val);
    `CHECK(rd_val, 16'h0101)
    u_mgr.wr(ADDR_SPEC_CTRL, 16'h000B);
    `CHECK(pin_out, 1'b0)
    pulse_irq(8'h01, 1'b1);
    u_mgr.rd(ADDR_IRQ_1, rd_val);
    @(negedge mclk);
    `CHECK(pin_out, 1'b0)
    u_mgr.wr(ADDR_BASIC_CTRL, 16'h0800);
    u_mgr.wr(ADDR_BASIC_CTRL, 16'h8000);
    @(negedge mclk);
    `CHECK(std_pulses, 1)
    u_mgr.rd(ADDR_BASIC_CTRL, rd_val);
    `CHECK(rd_val, 16'h0000)
    u_mgr.rd(ADDR_SPEC_CTRL, rd_val);
    `CHECK(rd_val, 16'h000B)
    u_mgr.wr(ADDR_GLOBAL_RST, 16'h4000);
    `CHECK(core_run, 1'b0)
    u_mgr.rd(ADDR_GLOBAL_RST, rd_val);
    `CHECK(rd_val, 16'h4000)
    wait_run(n);
    u_mgr.sw_wait();
    u_mgr.rd(ADDR_SPEC_CTRL, rd_val);
    `CHECK(rd_val, 16'h000B)
    u_mgr.rd(ADDR_IRQ_1, rd_val);
    `CHECK(rd_val, 16'h0001)
    strap_in = 8'h3C;
    u_mgr.wr(ADDR_GLOBAL_RST, 16'h8000);
    `CHECK(core_run, 1'b0)
    u_mgr.rd(ADDR_GLOBAL_RST, rd_val);
    `CHECK(rd_val, 16'h8000)
    wait_run(n);
    u_mgr.sw_wait();
    u_mgr.rd(ADDR_SPEC_CTRL, rd_val);
    `CHECK(rd_val, 16'h0000)
    `CHECK(strap_latched, 8'hA5)
    u_mgr.wr(ADDR_SPEC_CTRL, 16'h0001);
    u_mgr.pin_reset(250);
    `CHECK(core_run, 1'b0)
    wait_run(n);
    `CHECK(strap_latched, 8'h3C)
    u_mgr.rd(ADDR_SPEC_CTRL, rd_val);
    `CHECK({rd_val, pin_oe}, 17'h00000)
    end_of_test();
  end
endmodule : phy_reset_powerdown_interrupt_test

// ---- tb/station_manager.sv ----
// station management host and system reset model for the register port
`timescale 1ns/1ns
module station_manager
  import phy_rst_pkg::*;
#(
  parameter int WAIT_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rdata_valid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [4:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic hw_reset_n
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    hw_reset_n = 1'b1;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int i;
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    for (i = 0; i < 4 && reg_rdata_valid !== 1'b1; i++) @(negedge mclk);
    d = (reg_rdata_valid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask : rd

  task automatic pin_reset(input int cycles);
    @(negedge mclk);
    hw_reset_n = 1'b0;
    repeat (cycles) @(negedge mclk);
    hw_reset_n = 1'b1;
  endtask : pin_reset

  // quiet time after a software reset before further accesses
  task automatic sw_wait();
    repeat (WAIT_CYCLES) @(negedge mclk);
  endtask : sw_wait
endmodule : station_manager
